// *** src/conditional_jump_unit.sv ***
// conditional jump decision and sequencing
// assumes op_valid is a one-cycle pulse and registers hold during a jump
`timescale 1ns/100ps
`default_nettype none
`include "jump_unit_params.svh"
module conditional_jump_unit
	import jump_unit_pkg::*;
#(
	parameter int WIDTH = `WORD_W,
	parameter int AW = `ADDR_W
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic op_valid,
	input wire jump_op_e op_code,
	input wire logic [AW-1:0] op_addr,
	input wire logic [AW-1:0] next_seq_addr,
	input wire logic [WIDTH-1:0] acc_in,
	input wire logic [WIDTH-1:0] d_in,
	input wire logic [WIDTH-1:0] q_in,
	input wire logic acc_load,
	input wire logic [WIDTH-1:0] acc_load_word,
	output logic [WIDTH-1:0] d_reg,
	output logic d_write,
	output logic [AW-1:0] pc_out,
	output logic pc_load,
	output logic jump_taken,
	output logic [AW-1:0] jump_return_address_register,
	output logic busy
);
	jump_state_e state, next_state;
	jump_op_e op_hold, next_op_hold;
	logic [AW-1:0] addr_hold, next_addr_hold, seq_hold, next_seq_hold;
	logic [WIDTH-1:0] next_d_reg;
	logic next_d_write, next_pc_load, next_jump_taken, next_busy;
	logic [AW-1:0] next_pc_out, next_jra;
	logic cmp_eq, cmp_ge_alpha, cmp_ge_signed, cond;

	word_compare #(.WIDTH(WIDTH)) u_cmp (
		.acc(acc_in),
		.dval(d_reg),
		.equal(cmp_eq),
		.ge_alpha(cmp_ge_alpha),
		.ge_signed(cmp_ge_signed)
	);

	always_comb begin
		unique case (op_hold)
			jump_always: cond = 1'b1;
			// d positive, sign clear and nonzero
			jump_d_positive: cond = !d_reg[WIDTH-1] && (d_reg != '0);
			jump_acc_positive: cond = !acc_in[WIDTH-1] && (acc_in != '0);
			jump_acc_negative: cond = acc_in[WIDTH-1];
			// integer zero only, float zero not recognised
			jump_acc_zero: cond = (acc_in == '0);
			// equality against d or copied q
			jump_acc_equal_d, jump_acc_equal_q: cond = cmp_eq;
			jump_acc_ge_d_alpha: cond = cmp_ge_alpha;
			// both orders agree when signs are zero
			jump_acc_ge_q_numeric: cond = cmp_ge_signed;
			default: cond = 1'b0;
		endcase
	end

	always_comb begin
		next_state = state;
		next_op_hold = op_hold;
		next_addr_hold = addr_hold;
		next_seq_hold = seq_hold;
		next_d_reg = d_reg;
		next_d_write = 1'b0;
		next_pc_load = 1'b0;
		next_pc_out = pc_out;
		next_jump_taken = jump_taken;
		next_jra = jump_return_address_register;
		next_busy = busy;
		unique case (state)
			st_idle: begin
				if (acc_load) begin
					next_d_reg = acc_load_word;
					next_d_write = 1'b1;
				end
				if (op_valid && op_code != op_none) begin
					next_op_hold = op_code;
					next_addr_hold = op_addr;
					next_seq_hold = next_seq_addr;
					next_busy = 1'b1;
					// q goes to d before compare
					if (op_code == jump_acc_equal_q || op_code == jump_acc_ge_q_numeric) begin
						next_state = st_copy;
					end else begin
						next_state = st_decide;
					end
				end
			end
			st_copy: begin
				next_d_reg = q_in;
				next_d_write = 1'b1;
				next_state = st_decide;
			end
			st_decide: begin
				next_pc_load = 1'b1;
				next_jump_taken = cond;
				next_pc_out = cond ? addr_hold : seq_hold;
				next_jra = seq_hold;
				next_busy = 1'b0;
				next_state = st_idle;
			end
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= st_idle;
			op_hold <= op_none;
			addr_hold <= `ADDR_RESET;
			seq_hold <= `ADDR_RESET;
			d_reg <= '0;
			d_write <= 1'b0;
			pc_load <= 1'b0;
			pc_out <= `ADDR_RESET;
			jump_taken <= 1'b0;
			jump_return_address_register <= `ADDR_RESET;
			busy <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			op_hold <= next_op_hold;
			addr_hold <= next_addr_hold;
			seq_hold <= next_seq_hold;
			d_reg <= next_d_reg;
			d_write <= next_d_write;
			pc_load <= next_pc_load;
			pc_out <= next_pc_out;
			jump_taken <= next_jump_taken;
			jump_return_address_register <= next_jra;
			busy <= next_busy;
		end
	end

	chk_return_addr_saved: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_decide |=> jump_return_address_register == $past(seq_hold))
		else $error("return address not saved");
	chk_taken_target: assert property (@(posedge ref_clk) disable iff (!resetn)
		pc_load && jump_taken |-> pc_out == $past(addr_hold))
		else $error("taken jump wrong target");
	chk_fall_through: assert property (@(posedge ref_clk) disable iff (!resetn)
		pc_load && !jump_taken |-> pc_out == $past(seq_hold))
		else $error("fall through wrong target");
	chk_always_taken: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_decide && op_hold == jump_always |=> jump_taken)
		else $error("unconditional jump not taken");
	chk_q_copy: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_copy |=> d_reg == $past(q_in) && d_write)
		else $error("q not copied to d");
	chk_acc_through_d: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_idle && acc_load |=> d_reg == $past(acc_load_word))
		else $error("accumulator load missed d");
	chk_acc_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_decide && op_hold == jump_acc_zero
		|=> jump_taken == ($past(acc_in) == '0))
		else $error("zero test wrong");
	chk_acc_negative: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_decide && op_hold == jump_acc_negative
		|=> jump_taken == $past(acc_in[WIDTH-1]))
		else $error("negative test wrong");
	// numeric order matches character order with clear signs
	chk_ge_agree: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_decide && op_hold == jump_acc_ge_q_numeric
		&& !acc_in[WIDTH-1] && !d_reg[WIDTH-1] |=> jump_taken == ($past(acc_in) >= $past(d_reg)))
		else $error("ge orders disagree");
	chk_equal_full: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_decide && (op_hold == jump_acc_equal_d || op_hold == jump_acc_equal_q)
		|=> jump_taken == ($past(acc_in) == $past(d_reg)))
		else $error("equality decision wrong");
	chk_d_positive: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_decide && op_hold == jump_d_positive
		|=> jump_taken == (!$past(d_reg[WIDTH-1]) && $past(d_reg) != '0))
		else $error("d positive test wrong");
	// q ops always pass through the copy step
	chk_q_sequence: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_idle && op_valid && (op_code == jump_acc_equal_q || op_code == jump_acc_ge_q_numeric)
		|=> state == st_copy)
		else $error("q op skipped copy");
	// program counter load is a single pulse
	chk_pc_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && pc_load |=> !pc_load)
		else $error("pc load longer than one cycle");
	chk_freeze_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		!clk_en |=> $stable(state) && $stable(pc_out)
		&& $stable(jump_return_address_register) && $stable(busy))
		else $error("state moved while frozen");
	// op to decision within eight cycles, a short freeze included
	chk_decision_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
		clk_en && state == st_idle && op_valid && op_code != op_none
		|-> ##[1:8] pc_load)
		else $error("no decision in time");

	cov_taken: cover property (@(posedge ref_clk) disable iff (!resetn) pc_load && jump_taken);
	cov_not_taken: cover property (@(posedge ref_clk) disable iff (!resetn) pc_load && !jump_taken);
	cov_q_path: cover property (@(posedge ref_clk) disable iff (!resetn)
		state == st_copy ##1 state == st_decide);
	cov_frozen_op: cover property (@(posedge ref_clk) disable iff (!resetn)
		!clk_en && busy);
	cov_alpha_taken: cover property (@(posedge ref_clk) disable iff (!resetn)
		pc_load && jump_taken && op_hold == jump_acc_ge_d_alpha);
endmodule : conditional_jump_unit
`default_nettype wire

// *** src/jump_unit_params.svh ***
// constants for the conditional jump unit
// assumes a 48-bit word machine with 15-bit instruction addresses
`ifndef JUMP_UNIT_PARAMS_SVH
`define JUMP_UNIT_PARAMS_SVH
`define WORD_W 48
`define ADDR_W 15
`define CHAR_W 6
`define SIGN_BIT 47
`define ADDR_RESET 15'h0000
`endif

// *** src/jump_unit_pkg.sv ***
// types for the conditional jump unit
// assumes the params header is on the include path
package jump_unit_pkg;
	typedef enum logic [3:0] {
		op_none = 4'h0,
		jump_always = 4'h1,
		jump_d_positive = 4'h2,
		jump_acc_positive = 4'h3,
		jump_acc_negative = 4'h4,
		jump_acc_zero = 4'h5,
		jump_acc_equal_d = 4'h6,
		jump_acc_equal_q = 4'h7,
		jump_acc_ge_d_alpha = 4'h8,
		jump_acc_ge_q_numeric = 4'h9
	} jump_op_e;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_copy = 2'b01,
		st_decide = 2'b10
	} jump_state_e;
endpackage : jump_unit_pkg

// *** src/word_compare.sv ***
// combinational accumulator versus d comparator
// assumes both words are stable in the cycle they are read
`timescale 1ns/100ps
`default_nettype none
`include "jump_unit_params.svh"
module word_compare #(
	parameter int WIDTH = `WORD_W
) (
	input wire logic [WIDTH-1:0] acc,
	input wire logic [WIDTH-1:0] dval,
	output logic equal,
	output logic ge_alpha,
	output logic ge_signed
);
	always_comb begin
		equal = (acc == dval);
		// six-bit codes, zone bits above numeric, unsigned
		// zone is most significant so higher zone wins
		ge_alpha = (acc >= dval);
		ge_signed = ($signed(acc) >= $signed(dval));
	end
endmodule : word_compare
`default_nettype wire

// *** verification/tb_top.sv ***
// directed testbench for the conditional jump unit
// assumes the params header and package are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "jump_unit_params.svh"
module tb_top;
	import jump_unit_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic op_valid = 1'b0;
	logic acc_load = 1'b0;
	jump_op_e op_code = op_none;
	logic [14:0] op_addr = 15'h0000;
	logic [14:0] next_seq_addr = 15'h0000;
	logic [47:0] acc_in = 48'h0;
	logic [47:0] d_in = 48'h0;
	logic [47:0] q_in = 48'h0;
	logic [47:0] acc_load_word = 48'h0;
	logic [47:0] d_reg;
	logic d_write, pc_load, jump_taken, busy;
	logic [14:0] pc_out, jump_return_address_register;
	int failures = 0;
	int check_count = 0;
	always #10 ref_clk = ~ref_clk;
	conditional_jump_unit conditional_jump_unit_inst (.ref_clk, .resetn, .clk_en, .op_valid,
		.op_code, .op_addr, .next_seq_addr, .acc_in, .d_in, .q_in, .acc_load, .acc_load_word,
		.d_reg, .d_write, .pc_out, .pc_load, .jump_taken, .jump_return_address_register, .busy);
	task automatic summarize;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// d is seeded only through the accumulator load path
	task automatic load_d(input logic [47:0] w);
		@(negedge ref_clk);
		acc_load = 1'b1;
		acc_load_word = w;
		@(negedge ref_clk);
		acc_load = 1'b0;
		chk(d_reg, w);
	endtask : load_d
	task automatic run_op(input jump_op_e op, input logic [47:0] a, input logic [47:0] q,
		input logic exp);
		int n;
		logic dw;
		logic isq;
		dw = 1'b0;
		n = 0;
		isq = (op == jump_acc_equal_q) || (op == jump_acc_ge_q_numeric);
		@(negedge ref_clk);
		op_valid = 1'b1;
		op_code = op;
		acc_in = a;
		q_in = q;
		op_addr = op_addr + 15'h0123;
		next_seq_addr = op_addr ^ 15'h7f0f;
		@(negedge ref_clk);
		op_valid = 1'b0;
		while (pc_load !== 1'b1 && n < 8) begin
			if (d_write === 1'b1) dw = 1'b1;
			@(negedge ref_clk);
			n++;
		end
		if (pc_load !== 1'b1) begin
			chk(48'(pc_load), 48'h1);
			return;
		end
		// counted from the edge after op_valid drops
		chk(48'(n), isq ? 48'h2 : 48'h1);
		chk(48'(pc_out), exp ? 48'(op_addr) : 48'(next_seq_addr));
		chk(48'(jump_taken), 48'(exp));
		chk(48'(jump_return_address_register), 48'(next_seq_addr));
		if (isq) begin
			chk(48'(dw), 48'h1);
			chk(d_reg, q);
		end
	endtask : run_op
	task automatic t_acc;
		run_op(jump_always, 48'h800000000000, 48'h0, 1'b1);
		run_op(jump_acc_positive, 48'h000000000005, 48'h0, 1'b1);
		run_op(jump_acc_positive, 48'h0, 48'h0, 1'b0);
		run_op(jump_acc_negative, 48'h800000000000, 48'h0, 1'b1);
		run_op(jump_acc_negative, 48'h7fffffffffff, 48'h0, 1'b0);
		run_op(jump_acc_zero, 48'h0, 48'h0, 1'b1);
		run_op(jump_acc_zero, 48'h000000000001, 48'h0, 1'b0);
		$display("test acc done");
	endtask : t_acc
	task automatic t_dpos;
		load_d(48'h000000000001);
		run_op(jump_d_positive, 48'h0, 48'h0, 1'b1);
		load_d(48'h800000000001);
		run_op(jump_d_positive, 48'h0, 48'h0, 1'b0);
		$display("test d positive done");
	endtask : t_dpos
	task automatic t_equal;
		load_d(48'h123456789abc);
		run_op(jump_acc_equal_d, 48'h123456789abc, 48'h0, 1'b1);
		run_op(jump_acc_equal_d, 48'h123456789abd, 48'h0, 1'b0);
		run_op(jump_acc_equal_d, 48'h923456789abc, 48'h0, 1'b0);
		run_op(jump_acc_equal_q, 48'hfedcba987654, 48'hfedcba987654, 1'b1);
		run_op(jump_acc_equal_q, 48'h000000000001, 48'h0, 1'b0);
		$display("test equal done");
	endtask : t_equal
	// characters are zone then numeric, eight to a word
	task automatic t_ge;
		load_d({6'h1b, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08});
		run_op(jump_acc_ge_d_alpha, {6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08},
			48'h0, 1'b0);
		load_d({6'h11, 6'h12, 6'h13, 6'h01, 6'h02, 6'h03, 6'h04, 6'h04});
		run_op(jump_acc_ge_d_alpha, {6'h11, 6'h12, 6'h13, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05},
			48'h0, 1'b1);
		load_d({6'h0f, 42'h3ffffffffff});
		run_op(jump_acc_ge_d_alpha, {6'h10, 42'h0}, 48'h0, 1'b1);
		load_d(48'h000000000001);
		run_op(jump_acc_ge_d_alpha, 48'hffffffffffff, 48'h0, 1'b1);
		run_op(jump_acc_ge_q_numeric, 48'hffffffffffff, 48'h1, 1'b0);
		run_op(jump_acc_ge_q_numeric, 48'h1, 48'hffffffffffff, 1'b1);
		run_op(jump_acc_ge_q_numeric, 48'h5, 48'h5, 1'b1);
		load_d(48'h000000000007);
		run_op(jump_acc_ge_d_alpha, 48'h5, 48'h0, 1'b0);
		run_op(jump_acc_ge_q_numeric, 48'h5, 48'h7, 1'b0);
		$display("test ge done");
	endtask : t_ge
	// enable held low while the decision is pending
	task automatic t_freeze;
		@(negedge ref_clk);
		op_valid = 1'b1;
		op_code = jump_always;
		op_addr = 15'h1234;
		next_seq_addr = 15'h0abc;
		@(negedge ref_clk);
		op_valid = 1'b0;
		clk_en = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(48'(pc_load), 48'h0);
		chk(48'(busy), 48'h1);
		clk_en = 1'b1;
		@(negedge ref_clk);
		chk(48'(pc_load), 48'h1);
		chk(48'(pc_out), 48'h1234);
		chk(48'(jump_return_address_register), 48'h0abc);
		$display("test freeze done");
	endtask : t_freeze
	initial begin
		repeat (6) @(negedge ref_clk);
		chk(48'(pc_load), 48'h0);
		chk(48'(busy), 48'h0);
		resetn = 1'b1;
		t_acc();
		t_dpos();
		t_equal();
		t_ge();
		t_freeze();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
